/* common/fepm_pkg.sv */
// constants, field layout and mode codes for the event and power register logic
// How it works
// R1: event revision reads 00h absent, 01h present
// R2: host accepts larger event revisions as compatible
// R3: function count in low nibble, upper nibble zero
// R4: count 00h means flag word unused
// R5: count 01h holds one fixed flag bit
// R6: counts 02h-0Fh set and clear flags dynamically
// R7: flag word two bytes, bit n is function n
// R8: pending function event sets its flag bit
// R9: flag clears once no unsolved events remain
// R10: new event sets the flag bit again
// R11: host repeats event service until all resolved
// R12: per-function event enable gates bit 6, default off
// R13: function codes 0001h, 0002h, 0003h
// R14: power revision low nibble, first value 0000b
// R15: writes to power revision are ignored
// R16: three support bits in the upper nibble
// R17: power-off notification always reported supported
// R18: three ready bits follow the setting register
// R19: host sets request only when supported
// R20: power-off ready within one second of write
// R21: host waits busy, polls ready, then cuts power
// R22: after power-off request, unusable until power cycle
// R23: power-down ready follows request within one second
// R24: reset-to-idle in power-down exits to idle
// R25: sustenance ready follows request within one second
// R26: bits 0,1,2 per nibble, others read zero
package fepm_pkg;

   // register offsets inside the two register sets
   localparam logic [2:0] OFS_EVT_REV = 3'h0;
   localparam logic [2:0] OFS_EVT_CNT = 3'h1;
   localparam logic [2:0] OFS_EVT_FLAG_LO = 3'h2;
   localparam logic [2:0] OFS_EVT_FLAG_HI = 3'h3;
   localparam logic [2:0] OFS_EVT_EN_LO = 3'h4;
   localparam logic [2:0] OFS_EVT_EN_HI = 3'h5;
   localparam logic [2:0] OFS_PWR_REV = 3'h0;
   localparam logic [2:0] OFS_PWR_STAT = 3'h1;
   localparam logic [2:0] OFS_PWR_SET = 3'h2;
   localparam logic SPACE_EVENT = 1'b0;
   localparam logic SPACE_POWER = 1'b1;

   // fixed register values
   localparam logic [7:0] EVT_REV_ABSENT = 8'h00; // [R1]
   localparam logic [7:0] EVT_REV_PRESENT = 8'h01; // [R1]
   localparam logic [3:0] PWR_REV_VALUE = 4'h0; // [R14]
   localparam logic [3:0] ZERO_NIBBLE = 4'h0;
   localparam logic [15:0] SFC_POWER = 16'h0001; // [R13]
   localparam logic [15:0] SFC_PERFORMANCE = 16'h0002; // [R13]
   localparam logic [15:0] SFC_SECURITY_BOOT = 16'h0003; // [R13]

   // power function bit positions within each nibble [R26]
   localparam int NUM_PM = 3;
   localparam int BIT_POWEROFF = 0;
   localparam int BIT_SUSTAIN = 1;
   localparam int BIT_POWERDOWN = 2;
   localparam int SUPPORT_LSB = 4; // support bits start in the upper nibble

   // link sample word layout: {clk, wr, rd, space, addr[2:0], data[7:0], go_idle}
   localparam int LINK_W = 16;
   localparam int LNK_CLK = 15;
   localparam int LNK_WR = 14;
   localparam int LNK_RD = 13;
   localparam int LNK_SPACE = 12;
   localparam int LNK_ADDR = 9;
   localparam int LNK_DATA = 1;
   localparam int LNK_IDLE = 0;

   // timing: longest time for a ready bit to follow its request
   localparam int CLK_PERIOD_NS = 100;
   localparam int READY_LIMIT_US = 1000000;
   localparam int READY_LIMIT_CYCLES = READY_LIMIT_US * 1000 / CLK_PERIOD_NS;

   // power mode, one-hot
   typedef enum logic [2:0]
   {
      MODE_ACTIVE = 3'h1,
      MODE_DOWN = 3'h2,
      MODE_OFF = 3'h4
   } fepm_mode_type;

endpackage : fepm_pkg

/* common/fepm_ready_if.sv */
// request and ready handshake between the register logic and one ready timer
`timescale 1ns/1ns
`default_nettype none
interface fepm_ready_if;
   logic request;
   logic clear;
   logic ready;

   modport ctrl
   (
      output request,
      output clear,
      input ready
   );

   modport timer
   (
      input request,
      input clear,
      output ready
   );
endinterface : fepm_ready_if
`default_nettype wire

/* rtl/fepm_ready_timer.sv */
// ready bit that follows its request level after a settle delay
`timescale 1ns/1ns
`default_nettype none
module fepm_ready_timer
#(
   parameter int SETTLE_CYCLES = 1000
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // handshake with the register logic
   fepm_ready_if.timer port
);
   localparam int CW = $clog2(SETTLE_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(SETTLE_CYCLES - 1);
   localparam logic [CW-1:0] ONE = CW'(1);

   typedef struct packed
   {
      logic ready;
      logic [CW-1:0] count;
   } fepm_timer_state_type;

   fepm_timer_state_type st;
   fepm_timer_state_type next_st;

   // count while request and ready disagree; a change back clears the count
   // to zero, so a glitching request never flips ready
   always_comb
   begin
      next_st = st;
      if (port.clear)
      begin
         next_st.ready = 1'b0;
         next_st.count = '0;
      end
      else if (port.request != st.ready)
      begin
         if (st.count == LAST)
         begin
            next_st.ready = port.request; // [R18]
            next_st.count = '0;
         end
         else
         begin
            next_st.count = st.count + ONE;
         end
      end
      else
      begin
         next_st.count = '0;
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign port.ready = st.ready;
endmodule : fepm_ready_timer
`default_nettype wire

/* rtl/fepm_regs.sv */
// event flag and power management extension registers behind the card link
`timescale 1ns/1ns
`default_nettype none
module fepm_regs
#(
   parameter bit EVENT_SET_PRESENT = 1'b1,
   parameter int NUM_EVENT_FUNCS = 2,
   parameter int FIXED_EVENT_FUNC = 1,
   parameter bit SUPPORT_SUSTAIN = 1'b1,
   parameter bit SUPPORT_POWERDOWN = 1'b1,
   parameter int READY_LIMIT_CYCLES = fepm_pkg::READY_LIMIT_CYCLES,
   parameter int SETTLE_CYCLES = 5000
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // card link, all from the card clock domain
   input wire logic sd_clk,
   input wire logic ext_wr,
   input wire logic ext_rd,
   input wire logic ext_space,
   input wire logic [2:0] ext_addr,
   input wire logic [7:0] ext_wdata,
   input wire logic cmd_go_idle,
   // read answer
   output logic [7:0] ext_rdata,
   output logic ext_rvalid,
   // per-function event state, same clock
   input wire logic [15:0] func_event_pending,
   // event indication for bit 6 of the normal response
   output logic response_event_bit,
   output logic [15:0] event_flag_word,
   // power state
   output logic poweroff_ready,
   output logic sustain_ready,
   output logic powerdown_ready,
   output logic card_unusable,
   output logic enter_idle
);
   // the settle delay never exceeds the one second limit
   localparam int EFF_SETTLE = (SETTLE_CYCLES < READY_LIMIT_CYCLES) ?
                               SETTLE_CYCLES : READY_LIMIT_CYCLES;
   localparam int SETTLE_USED = (EFF_SETTLE < 1) ? 1 : EFF_SETTLE;
   localparam logic [3:0] FUNC_COUNT = EVENT_SET_PRESENT ? 4'(NUM_EVENT_FUNCS) : 4'h0;
   localparam logic [15:0] FIXED_FLAG = 16'h0001 << FIXED_EVENT_FUNC;
   localparam logic [2:0] SUPPORT_MASK = {SUPPORT_POWERDOWN, SUPPORT_SUSTAIN, 1'b1};

   typedef struct packed
   {
      logic [fepm_pkg::LINK_W-1:0] sync1;
      logic [fepm_pkg::LINK_W-1:0] sync2;
      logic clk_prev;
      logic [7:0] rdata;
      logic rvalid;
      logic [15:0] flags;
      logic [15:0] enable;
      logic event_bit;
      logic [2:0] request;
      fepm_pkg::fepm_mode_type mode;
      logic idle_pulse;
   } fepm_regs_state_type;

   localparam fepm_regs_state_type RESET_ST = '{
      sync1: '0,
      sync2: '0,
      clk_prev: 1'b0,
      rdata: 8'h00,
      rvalid: 1'b0,
      flags: 16'h0000,
      enable: 16'h0000,
      event_bit: 1'b0,
      request: 3'h0,
      mode: fepm_pkg::MODE_ACTIVE,
      idle_pulse: 1'b0
   };

   fepm_regs_state_type st;
   fepm_regs_state_type next_st;

   logic [fepm_pkg::LINK_W-1:0] link_raw;
   logic [fepm_pkg::NUM_PM-1:0] ready_vec;
   logic [fepm_pkg::NUM_PM-1:0] clear_vec;
   logic link_edge;
   logic link_wr;
   logic link_rd;
   logic link_space;
   logic link_idle;
   logic [2:0] link_addr;
   logic [7:0] link_data;
   logic [7:0] status_byte;
   logic [7:0] setting_byte;
   logic [7:0] read_byte;
   logic [2:0] write_req;

   // gather the link pins into one word for the synchroniser
   assign link_raw = {sd_clk, ext_wr, ext_rd, ext_space, ext_addr, ext_wdata, cmd_go_idle};

   // only the second stage is decoded; address and data are held stable by the
   // command engine across the card clock edge, so a skewed bit settles well
   // before the edge is seen, nine or more system clocks per card clock
   assign link_edge = st.sync2[fepm_pkg::LNK_CLK] & ~st.clk_prev;
   assign link_wr = st.sync2[fepm_pkg::LNK_WR];
   assign link_rd = st.sync2[fepm_pkg::LNK_RD];
   assign link_space = st.sync2[fepm_pkg::LNK_SPACE];
   assign link_addr = st.sync2[fepm_pkg::LNK_ADDR +: 3];
   assign link_data = st.sync2[fepm_pkg::LNK_DATA +: 8];
   assign link_idle = st.sync2[fepm_pkg::LNK_IDLE];

   // ready timers, one per power function
   fepm_ready_if rdy_if [fepm_pkg::NUM_PM] ();

   genvar g;
   generate
      for (g = 0; g < fepm_pkg::NUM_PM; g++)
      begin : g_pm
         assign rdy_if[g].request = st.request[g];
         assign rdy_if[g].clear = clear_vec[g];
         assign ready_vec[g] = rdy_if[g].ready;

         fepm_ready_timer
         #(
            .SETTLE_CYCLES(SETTLE_USED)
         )
         u_timer
         (
            .sys_clk(sys_clk),
            .nrst(nrst),
            .port(rdy_if[g].timer)
         );
      end
   endgenerate

   // power-down ready drops at once when reset-to-idle aborts power-down
   always_comb
   begin
      clear_vec = 3'h0;
      clear_vec[fepm_pkg::BIT_POWERDOWN] = st.idle_pulse; // [R24]
   end

   // status: support in the upper nibble, readiness in the lower
   always_comb
   begin
      status_byte = 8'h00;
      status_byte[fepm_pkg::SUPPORT_LSB +: fepm_pkg::NUM_PM] = SUPPORT_MASK; // [R16] [R17] [R26]
      status_byte[0 +: fepm_pkg::NUM_PM] = ready_vec; // [R18] [R26]
      setting_byte = 8'h00;
      setting_byte[0 +: fepm_pkg::NUM_PM] = st.request; // [R26]
   end

   // read multiplexer; unmapped offsets read zero
   always_comb
   begin
      read_byte = 8'h00;
      if (link_space == fepm_pkg::SPACE_EVENT)
      begin
         unique case (link_addr)
            fepm_pkg::OFS_EVT_REV:
               read_byte = EVENT_SET_PRESENT ? fepm_pkg::EVT_REV_PRESENT :
                           fepm_pkg::EVT_REV_ABSENT; // [R1]
            fepm_pkg::OFS_EVT_CNT:
               read_byte = {fepm_pkg::ZERO_NIBBLE, FUNC_COUNT}; // [R3]
            fepm_pkg::OFS_EVT_FLAG_LO:
               read_byte = st.flags[7:0]; // [R7]
            fepm_pkg::OFS_EVT_FLAG_HI:
               read_byte = st.flags[15:8]; // [R7]
            fepm_pkg::OFS_EVT_EN_LO:
               read_byte = st.enable[7:0];
            fepm_pkg::OFS_EVT_EN_HI:
               read_byte = st.enable[15:8];
            default:
               read_byte = 8'h00;
         endcase
      end
      else
      begin
         unique case (link_addr)
            fepm_pkg::OFS_PWR_REV:
               read_byte = {fepm_pkg::ZERO_NIBBLE, fepm_pkg::PWR_REV_VALUE}; // [R14]
            fepm_pkg::OFS_PWR_STAT:
               read_byte = status_byte;
            fepm_pkg::OFS_PWR_SET:
               read_byte = setting_byte;
            default:
               read_byte = 8'h00;
         endcase
      end
   end

   // unsupported requests are masked off; power-off never comes back to zero
   always_comb
   begin
      write_req = link_data[0 +: fepm_pkg::NUM_PM] & SUPPORT_MASK; // [R19]
      write_req[fepm_pkg::BIT_POWEROFF] = write_req[fepm_pkg::BIT_POWEROFF] |
                                          st.request[fepm_pkg::BIT_POWEROFF]; // [R22]
   end

   // main next-state logic
   always_comb
   begin
      next_st = st;
      next_st.sync1 = link_raw;
      next_st.sync2 = st.sync1;
      next_st.clk_prev = st.sync2[fepm_pkg::LNK_CLK];
      next_st.rvalid = 1'b0;
      next_st.idle_pulse = 1'b0;

      // event flags track each function's pending state for counts 02h-0Fh
      unique case (FUNC_COUNT)
         4'h0:
            next_st.flags = 16'h0000; // [R4]
         4'h1:
            next_st.flags = FIXED_FLAG; // [R5]
         default:
            next_st.flags = func_event_pending; // [R6] [R8] [R9] [R10]
      endcase

      // bit 6 only reports functions whose event enable is set
      next_st.event_bit = (FUNC_COUNT != 4'h0) &&
                          ((next_st.flags & st.enable) != 16'h0000); // [R12]

      // accesses happen on the sampled rising edge of the card clock
      if (link_edge)
      begin
         if (link_rd)
         begin
            next_st.rdata = read_byte;
            next_st.rvalid = 1'b1;
         end
         if (link_wr && st.mode != fepm_pkg::MODE_OFF) // [R22]
         begin
            if (link_space == fepm_pkg::SPACE_EVENT)
            begin
               // revision, count and flags are read-only; only enables take data
               if (link_addr == fepm_pkg::OFS_EVT_EN_LO)
               begin
                  next_st.enable[7:0] = link_data; // [R12]
               end
               else if (link_addr == fepm_pkg::OFS_EVT_EN_HI)
               begin
                  next_st.enable[15:8] = link_data; // [R12]
               end
            end
            else if (link_addr == fepm_pkg::OFS_PWR_SET)
            begin
               // revision and status writes fall through untouched
               next_st.request = write_req; // [R15] [R20] [R23] [R25]
            end
         end
         // reset-to-idle aborts power-down and drops its request
         if (link_idle && st.mode == fepm_pkg::MODE_DOWN)
         begin
            next_st.request[fepm_pkg::BIT_POWERDOWN] = 1'b0; // [R24]
            next_st.idle_pulse = 1'b1; // [R24]
         end
      end

      // mode follows requests and readiness
      if (next_st.request[fepm_pkg::BIT_POWEROFF])
      begin
         next_st.mode = fepm_pkg::MODE_OFF; // [R22]
      end
      else if (next_st.idle_pulse)
      begin
         next_st.mode = fepm_pkg::MODE_ACTIVE; // [R24]
      end
      else if (ready_vec[fepm_pkg::BIT_POWERDOWN] && st.request[fepm_pkg::BIT_POWERDOWN])
      begin
         next_st.mode = fepm_pkg::MODE_DOWN;
      end
      else if (!ready_vec[fepm_pkg::BIT_POWERDOWN])
      begin
         next_st.mode = fepm_pkg::MODE_ACTIVE;
      end
   end

   // state register; only constants at reset
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st <= RESET_ST;
      end
      else
      begin
         st <= next_st;
      end
   end

   // outputs come from flip-flops here or in the timers, except card_unusable, which is decoded from the mode register
   assign ext_rdata = st.rdata;
   assign ext_rvalid = st.rvalid;
   assign response_event_bit = st.event_bit;
   assign event_flag_word = st.flags;
   assign poweroff_ready = ready_vec[fepm_pkg::BIT_POWEROFF]; // [R20]
   assign sustain_ready = ready_vec[fepm_pkg::BIT_SUSTAIN]; // [R25]
   assign powerdown_ready = ready_vec[fepm_pkg::BIT_POWERDOWN]; // [R23]
   assign card_unusable = (st.mode == fepm_pkg::MODE_OFF); // [R22]
   assign enter_idle = st.idle_pulse;
endmodule : fepm_regs
`default_nettype wire

/* test/fepm_checker.sv */
// concurrent checks on the event flag and power management register ports
`timescale 1ns/1ns
`default_nettype none
module fepm_checker
#(
   parameter int SETTLE_CYCLES = 5000
)
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // event side
   input wire logic [15:0] func_event_pending,
   input wire logic response_event_bit,
   input wire logic [15:0] event_flag_word,
   // power side
   input wire logic poweroff_ready,
   input wire logic sustain_ready,
   input wire logic powerdown_ready,
   input wire logic card_unusable,
   input wire logic enter_idle
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   // cycles spent waiting for power-off ready; a counter because the settle may be long
   int wait_cnt;
   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst)
         wait_cnt <= 0;
      else if (card_unusable && !poweroff_ready)
         wait_cnt <= wait_cnt + 1;
      else
         wait_cnt <= 0;

   chk_ready_window: assert property (wait_cnt <= SETTLE_CYCLES + 2)
      else $error("power-off ready late");
   chk_off_sticky: assert property (card_unusable |=> card_unusable)
      else $error("unusable state left");
   chk_offready_hold: assert property (poweroff_ready |=> poweroff_ready)
      else $error("power-off ready dropped");
   chk_flag_follow: assert property (1'b1 |=> event_flag_word == $past(func_event_pending))
      else $error("flag word not following pending");
   chk_resp_gate: assert property (response_event_bit |-> event_flag_word != 16'h0000)
      else $error("event bit without flag");
   chk_ready_settle: assert property ($changed(sustain_ready) |=> $stable(sustain_ready)[*3])
      else $error("sustain ready toggles too fast");
   chk_idle_pulse: assert property (enter_idle |=> !enter_idle)
      else $error("idle pulse too long");
   chk_idle_drop: assert property (enter_idle |=> !powerdown_ready)
      else $error("power-down ready kept after idle");
   chk_idle_cause: assert property (enter_idle |-> $past(powerdown_ready))
      else $error("idle entry outside power-down");
endmodule : fepm_checker
bind fepm_regs fepm_checker #(.SETTLE_CYCLES(SETTLE_CYCLES)) fepm_checker_i
(
   .sys_clk(sys_clk),
   .nrst(nrst),
   .func_event_pending(func_event_pending),
   .response_event_bit(response_event_bit),
   .event_flag_word(event_flag_word),
   .poweroff_ready(poweroff_ready),
   .sustain_ready(sustain_ready),
   .powerdown_ready(powerdown_ready),
   .card_unusable(card_unusable),
   .enter_idle(enter_idle)
);
`default_nettype wire

/* test/fepm_host_model.sv */
// host controller model driving one register access per card clock edge
`timescale 1ns/1ns
`default_nettype none
module fepm_host_model
(
   // clock
   input wire logic sys_clk,
   // link toward the card
   output var logic sd_clk,
   output var logic ext_wr,
   output var logic ext_rd,
   output var logic ext_space,
   output var logic [2:0] ext_addr,
   output var logic [7:0] ext_wdata,
   output var logic cmd_go_idle,
   // read answer
   input wire logic [7:0] ext_rdata,
   input wire logic ext_rvalid
);
   // idle link: clock parked low, strobes off
   initial
   begin
      {sd_clk, ext_wr, ext_rd, ext_space, ext_addr, ext_wdata, cmd_go_idle} = '0;
   end

   // one frame; the card clock runs only inside it and strobes hold 400 ns on both sides
   // a read that never answers returns unknown, so it cannot pass for a zero byte
   task automatic access(input logic wr, input logic rd, input logic sp,
      input logic [2:0] adr, input logic [7:0] dat, input logic go, output logic [7:0] rdat);
      rdat = 8'hxx;
      @(posedge sys_clk);
      #1;
      {ext_wr, ext_rd, ext_space, ext_addr, ext_wdata, cmd_go_idle} = {wr, rd, sp, adr, dat, go};
      repeat (4) @(posedge sys_clk);
      #1 sd_clk = 1'b1;
      repeat (4)
      begin
         @(posedge sys_clk);
         #1;
         if (ext_rvalid === 1'b1)
            rdat = ext_rdata;
      end
      sd_clk = 1'b0;
      {ext_wr, ext_rd, cmd_go_idle} = 3'h0;
      // released lines show the inverse so stale data cannot pass for a drive
      ext_addr = ~adr;
      ext_wdata = ~dat;
   endtask : access
endmodule : fepm_host_model
`default_nettype wire

/* test/test_fepm_regs.sv */
// self-checking bench for the event flag and power management registers
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_mismatch++; $display("BAD %0t got %h expected %h", $time, got, exp); end end
module test_fepm_regs;
   localparam int SETTLE = 4;
   localparam logic EV = fepm_pkg::SPACE_EVENT;
   localparam logic PW = fepm_pkg::SPACE_POWER;
   logic sys_clk, nrst, sd_clk, ext_wr, ext_rd, ext_space, cmd_go_idle, ext_rvalid;
   logic [2:0] ext_addr;
   logic [7:0] ext_wdata, ext_rdata, rd_val;
   logic [15:0] func_event_pending, event_flag_word;
   logic response_event_bit, poweroff_ready, sustain_ready, powerdown_ready;
   logic card_unusable, enter_idle;
   int n_mismatch = 0;
   int checks = 0;
   int cycles = 0;

   fepm_regs #(.READY_LIMIT_CYCLES(8), .SETTLE_CYCLES(SETTLE)) fepm_regs_i
   (
      .sys_clk(sys_clk), .nrst(nrst), .sd_clk(sd_clk), .ext_wr(ext_wr), .ext_rd(ext_rd),
      .ext_space(ext_space), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
      .cmd_go_idle(cmd_go_idle), .ext_rdata(ext_rdata), .ext_rvalid(ext_rvalid),
      .func_event_pending(func_event_pending), .response_event_bit(response_event_bit),
      .event_flag_word(event_flag_word), .poweroff_ready(poweroff_ready),
      .sustain_ready(sustain_ready), .powerdown_ready(powerdown_ready),
      .card_unusable(card_unusable), .enter_idle(enter_idle)
   );

   fepm_host_model fepm_host_model_i
   (
      .sys_clk(sys_clk), .sd_clk(sd_clk), .ext_wr(ext_wr), .ext_rd(ext_rd),
      .ext_space(ext_space), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
      .cmd_go_idle(cmd_go_idle), .ext_rdata(ext_rdata), .ext_rvalid(ext_rvalid)
   );

   // 10 MHz system clock
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic give_verdict();
      if (n_mismatch == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : give_verdict

   // hang guard, well above the few hundred cycles the sequence needs
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end

   task automatic reg_wr(input logic sp, input logic [2:0] adr, input logic [7:0] dat);
      fepm_host_model_i.access(1'b1, 1'b0, sp, adr, dat, 1'b0, rd_val);
   endtask : reg_wr

   task automatic rd_chk(input logic sp, input logic [2:0] adr, input logic [7:0] exp);
      fepm_host_model_i.access(1'b0, 1'b1, sp, adr, 8'h00, 1'b0, rd_val);
      `CHK(rd_val, exp)
   endtask : rd_chk

   // pending level changes just after an edge, then flags get time to land
   // repeated calls stand for the host servicing events until all clear
   task automatic set_pending(input logic [15:0] v);
      @(posedge sys_clk);
      #1 func_event_pending = v;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask : set_pending

   // ready bits need the settle count plus the link latency
   task automatic settle();
      repeat (SETTLE * 5) @(posedge sys_clk);
   endtask : settle

   initial
   begin
      nrst = 1'b0;
      func_event_pending = 16'h0000;
      repeat (16) @(posedge sys_clk);
      #1 nrst = 1'b1;
      repeat (4) @(posedge sys_clk);
      // fixed values after reset, unmapped offset and ignored write
      rd_chk(EV, fepm_pkg::OFS_EVT_REV, 8'h01);
      rd_chk(EV, fepm_pkg::OFS_EVT_CNT, 8'h02);
      rd_chk(PW, fepm_pkg::OFS_PWR_REV, 8'h00);
      rd_chk(PW, fepm_pkg::OFS_PWR_STAT, 8'h70);
      rd_chk(EV, 3'h7, 8'h00);
      reg_wr(PW, fepm_pkg::OFS_PWR_REV, 8'h0f);
      rd_chk(PW, fepm_pkg::OFS_PWR_REV, 8'h00);
      // flags follow events while the enable starts off
      set_pending(16'h8001);
      `CHK(response_event_bit, 1'b0)
      rd_chk(EV, fepm_pkg::OFS_EVT_FLAG_LO, 8'h01);
      rd_chk(EV, fepm_pkg::OFS_EVT_FLAG_HI, 8'h80);
      reg_wr(EV, fepm_pkg::OFS_EVT_EN_LO, 8'h01);
      rd_chk(EV, fepm_pkg::OFS_EVT_EN_LO, 8'h01);
      `CHK(response_event_bit, 1'b1)
      set_pending(16'h0000);
      `CHK(event_flag_word, 16'h0000)
      `CHK(response_event_bit, 1'b0)
      set_pending(16'h0001);
      `CHK(event_flag_word, 16'h0001)
      // sustenance on and off, only supported bits written
      reg_wr(PW, fepm_pkg::OFS_PWR_SET, 8'h02);
      settle();
      rd_chk(PW, fepm_pkg::OFS_PWR_STAT, 8'h72);
      `CHK(sustain_ready, 1'b1)
      reg_wr(PW, fepm_pkg::OFS_PWR_SET, 8'h00);
      settle();
      rd_chk(PW, fepm_pkg::OFS_PWR_STAT, 8'h70);
      // power-down entered, then aborted by reset-to-idle
      reg_wr(PW, fepm_pkg::OFS_PWR_SET, 8'h04);
      settle();
      rd_chk(PW, fepm_pkg::OFS_PWR_STAT, 8'h74);
      fepm_host_model_i.access(1'b0, 1'b0, EV, 3'h0, 8'h00, 1'b1, rd_val);
      repeat (4) @(posedge sys_clk);
      `CHK(powerdown_ready, 1'b0)
      rd_chk(PW, fepm_pkg::OFS_PWR_SET, 8'h00);
      // power-off notification, then writes no longer take effect
      reg_wr(PW, fepm_pkg::OFS_PWR_SET, 8'h01);
      `CHK(card_unusable, 1'b1)
      settle();
      rd_chk(PW, fepm_pkg::OFS_PWR_STAT, 8'h71);
      `CHK(poweroff_ready, 1'b1)
      reg_wr(PW, fepm_pkg::OFS_PWR_SET, 8'h00);
      rd_chk(PW, fepm_pkg::OFS_PWR_SET, 8'h01);
      give_verdict();
   end
endmodule : test_fepm_regs
`default_nettype wire
